/* File: logic/asrp_host.sv */
// host end: register slave on the system bus that runs one conversion and readout
`timescale 1ns/1ps
module asrp_host
  import asrp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // serial link
  asrp_if.host             link,
  // system bus slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  typedef struct packed {
    logic                  sdoMeta;
    logic                  sdoSync;
    asrp_host_state_t      st;
    logic [HOST_CNT_W-1:0] cnt;
    logic [4:0]            pulses;
    logic [15:0]           capture;
    logic [15:0]           dataReg;
    logic                  dataValid;
    logic                  fourWire;
    logic                  useBusy;
    logic                  conversion_start_input;
    logic                  sck;
    logic                  sdi;
    logic                  aphWrite;
    logic [7:0]            aphAddr;
    logic [31:0]           rdata;
  } asrp_host_regs_t;

  asrp_host_regs_t s_reg;
  asrp_host_regs_t s_next;

  logic       accept;
  logic       startCmd;
  logic [4:0] lastPulse;

  // bus address phase taken when selected and the bus is ready
  assign accept   = hsel & htrans[1] & hready;
  assign startCmd = s_reg.aphWrite & (s_reg.aphAddr == REG_CTRL) & hwdata[CTRL_START_BIT];
  assign lastPulse = s_reg.useBusy ? 5'(FALLS_BUSY - 1) : 5'(FALLS_PLAIN - 1);

  // next state of bus slave and link sequencer
  always_comb begin
    s_next         = s_reg;
    s_next.sdoMeta = link.sdoLine;
    s_next.sdoSync = s_reg.sdoMeta;

    // data phase of a write
    s_next.aphWrite = 1'b0;
    if (s_reg.aphWrite && s_reg.aphAddr == REG_CTRL) begin
      s_next.fourWire = hwdata[CTRL_FOUR_WIRE_BIT];
      s_next.useBusy  = hwdata[CTRL_BUSY_BIT];
    end

    // address phase: latch write, load read data for the data phase
    if (accept) begin
      s_next.aphWrite = hwrite;
      s_next.aphAddr  = haddr[7:0];
      s_next.rdata    = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          REG_CTRL: begin
            s_next.rdata[CTRL_FOUR_WIRE_BIT] = s_reg.fourWire;
            s_next.rdata[CTRL_BUSY_BIT]      = s_reg.useBusy;
          end
          REG_STATUS: begin
            s_next.rdata[STAT_BUSY_BIT]  = (s_reg.st != HOST_IDLE);
            s_next.rdata[STAT_VALID_BIT] = s_reg.dataValid;
          end
          REG_DATA: begin
            s_next.rdata[15:0] = s_reg.dataReg;
            s_next.dataValid   = 1'b0;
          end
          default: begin
            s_next.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // link sequencer
    case (s_reg.st)
      HOST_IDLE: begin
        s_next.sck = 1'b0;
        s_next.sdi = 1'b1;
        if (startCmd) begin
          // data-in high at the start rise selects select-readout mode
          s_next.conversion_start_input = 1'b1;
          s_next.cnt = '0;
          s_next.st  = HOST_LAUNCH;
        end
      end
      HOST_LAUNCH: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == HOST_CNT_W'(SEL_LEAD_CYCLES - 1)) begin
          s_next.cnt = '0;
          s_next.st  = HOST_WAIT;
          if (s_reg.useBusy) begin
            // select early and hold through the conversion
            if (s_reg.fourWire) begin
              s_next.sdi = 1'b0;
            end else begin
              s_next.conversion_start_input = 1'b0;
            end
          end
        end
      end
      HOST_WAIT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.useBusy) begin
          if (!s_reg.sdoSync) begin
            // start bit seen on the pulled-up line
            s_next.cnt    = '0;
            s_next.pulses = '0;
            s_next.st     = HOST_LOW;
          end
        end else if (s_reg.cnt == HOST_CNT_W'(CONV_CYCLES + SYNC_MARGIN_CYCLES)) begin
          // start and data-in held high until maximum time passed
          s_next.cnt    = '0;
          s_next.pulses = '0;
          s_next.st     = HOST_LOW;
          if (s_reg.fourWire) begin
            s_next.sdi = 1'b0;
          end else begin
            s_next.conversion_start_input = 1'b0;
          end
        end
      end
      HOST_LOW: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == HOST_CNT_W'(SCK_HALF_CYCLES - 1)) begin
          s_next.cnt = '0;
          s_next.sck = 1'b1;
          s_next.st  = HOST_HIGH;
        end
      end
      HOST_HIGH: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == HOST_CNT_W'(SCK_HALF_CYCLES - 1)) begin
          // sample just before the fall; the bit stood since the last fall
          s_next.capture = {s_reg.capture[14:0], s_reg.sdoSync};
          s_next.sck     = 1'b0;
          s_next.cnt     = '0;
          s_next.pulses  = s_reg.pulses + 1'b1;
          s_next.st      = HOST_LOW;
          if (s_reg.pulses == lastPulse) begin
            s_next.dataReg   = {s_reg.capture[14:0], s_reg.sdoSync};
            s_next.dataValid = 1'b1;
            s_next.st        = HOST_DONE;
          end
        end
      end
      HOST_DONE: begin
        // release the select and leave start low for the next rise
        s_next.sdi = 1'b1;
        s_next.conversion_start_input = 1'b0;
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == HOST_CNT_W'(SCK_HALF_CYCLES - 1)) begin
          s_next.st = HOST_IDLE;
        end
      end
      default: begin
        s_next.st = HOST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg          <= '0;
      s_reg.fourWire <= CTRL_FOUR_WIRE_RST;
      s_reg.useBusy  <= CTRL_BUSY_RST;
      s_reg.sdi      <= 1'b1;
      s_reg.sdoMeta  <= 1'b1;
      s_reg.sdoSync  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus answer and link pins
  assign hrdata         = s_reg.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign link.convStart = s_reg.conversion_start_input;
  assign link.sck       = s_reg.sck;
  assign link.sdi       = s_reg.sdi;

endmodule : asrp_host

/* File: logic/asrp_pkg.sv */
// shared constants and state types of the serial readout port
package asrp_pkg;

  // clock and conversion timing
  localparam int CLK_PERIOD_NS      = 5;
  localparam int CONV_MAX_NS        = 500;
  localparam int CONV_CYCLES        = (CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W         = 8;
  localparam int SEL_LEAD_CYCLES    = 4;
  localparam int SYNC_MARGIN_CYCLES = 8;
  localparam int HOST_CNT_W         = 9;
  localparam int SCK_HALF_CYCLES    = 8;

  // result format and readout lengths
  localparam int          DATA_BITS   = 16;
  localparam int          FALLS_PLAIN = 16;
  localparam int          FALLS_BUSY  = 17;
  localparam logic [15:0] CODE_MAX    = 16'hFFFF;
  localparam logic [15:0] CODE_MIN    = 16'h0000;

  // host register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;

  // control and status fields
  localparam int   CTRL_START_BIT     = 0;
  localparam int   CTRL_FOUR_WIRE_BIT = 1;
  localparam int   CTRL_BUSY_BIT      = 2;
  localparam int   STAT_BUSY_BIT      = 0;
  localparam int   STAT_VALID_BIT     = 1;
  localparam logic CTRL_FOUR_WIRE_RST = 1'b0;
  localparam logic CTRL_BUSY_RST      = 1'b0;

  // device and host sequencer states
  typedef enum logic [1:0] {
    DEV_STANDBY, DEV_CONVERT, DEV_READY, DEV_SHIFT
  } asrp_dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE, HOST_LAUNCH, HOST_WAIT, HOST_LOW, HOST_HIGH, HOST_DONE
  } asrp_host_state_t;

endpackage : asrp_pkg

/* File: logic/asrp_if.sv */
// link between converter port and host: start, clock, select and data line
`timescale 1ns/1ps
interface asrp_if;
  logic convStart;
  logic sck;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  logic sdoLine;

  // data line level with a pull-up when nobody drives it
  assign sdoLine = sdoOe ? sdoOut : 1'b1;

  modport device (input convStart, input sck, input sdi, output sdoOut, output sdoOe);
  modport host (output convStart, output sck, output sdi, input sdoLine);
endinterface : asrp_if

/* File: logic/asrp_device.sv */
// converter end: mode select, timed conversion, busy start bit and serial readout
// Contract
// - start rise selects mode from data-in level
// - data-in tied to start gives select mode
// - select mode busy if start/data-in low
// - chain busy only if clock high
// - without busy host waits maximum conversion time
// - start rise begins conversion, output floats
// - conversion completes whatever start does
// - 3-wire host restores start high early
// - completion enters acquisition then standby
// - 3-wire start fall shows MSB, falls shift
// - bits hold across both clock edges
// - float at 16th fall or start rise
// - 3-wire busy host holds start low
// - busy drives output low at completion
// - busy float at 17th fall or start rise
// - both select inputs low drives output low
// - 4-wire host restores data-in high early
// - 4-wire data-in fall shows MSB
// - 4-wire float at 16th fall or rise
// - 4-wire busy host holds data-in low
// - 4-wire busy float at 17th fall
// - internal timer runs conversion, clock not needed
// - straight binary result clamped to range
`timescale 1ns/1ps
module asrp_device
  import asrp_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               resetn,
  // serial link
  asrp_if.device                  link,
  // analog stand-in, sampled at the start edge
  input  wire logic signed [17:0] sampleIn,
  // status toward the user side
  output logic             [15:0] resultOut,
  output logic                    converting,
  output logic                    chainMode,
  output logic                    busyMode,
  output logic                    readoutActive
);

  typedef struct packed {
    logic                  cnvMeta;
    logic                  cnvSync;
    logic                  cnvPrev;
    logic                  sckMeta;
    logic                  sckSync;
    logic                  sckPrev;
    logic                  sdiMeta;
    logic                  sdiSync;
    asrp_dev_state_t       st;
    logic                  chain;
    logic                  busyChain;
    logic                  busy;
    logic [CONV_CNT_W-1:0] convCnt;
    logic [15:0]           shiftReg;
    logic [4:0]            fallCnt;
    logic [15:0]           result;
    logic                  sdoOut;
    logic                  sdoOe;
  } asrp_dev_regs_t;

  asrp_dev_regs_t s_reg;
  asrp_dev_regs_t s_next;

  logic        cnvRise;
  logic        sckFall;
  logic        selected;
  logic        busyNow;
  logic [15:0] clampCode;
  logic [4:0]  lastFall;

  // edge and level views of the synchronised link inputs
  assign cnvRise  = s_reg.cnvSync & ~s_reg.cnvPrev;
  assign sckFall  = ~s_reg.sckSync & s_reg.sckPrev;
  assign selected = ~(s_reg.cnvSync & s_reg.sdiSync);

  // busy start bit decision taken at the end of conversion
  always_comb begin
    if (s_reg.chain) begin
      busyNow = s_reg.busyChain;
    end else begin
      busyNow = ~s_reg.cnvSync | ~s_reg.sdiSync;
    end
  end

  // fall count that ends a select-mode readout
  assign lastFall = s_reg.busy ? 5'(FALLS_BUSY - 1) : 5'(FALLS_PLAIN - 1);

  // straight binary code, out-of-range inputs pinned to the end codes
  always_comb begin
    if (sampleIn[17]) begin
      clampCode = CODE_MIN;
    end else if (sampleIn[16]) begin
      clampCode = CODE_MAX;
    end else begin
      clampCode = sampleIn[15:0];
    end
  end

  // next state of the whole port
  always_comb begin
    s_next = s_reg;
    // two-stage synchronisers, then one stage for edge finding
    s_next.cnvMeta = link.convStart;
    s_next.cnvSync = s_reg.cnvMeta;
    s_next.cnvPrev = s_reg.cnvSync;
    s_next.sckMeta = link.sck;
    s_next.sckSync = s_reg.sckMeta;
    s_next.sckPrev = s_reg.sckSync;
    s_next.sdiMeta = link.sdi;
    s_next.sdiSync = s_reg.sdiMeta;

    if (cnvRise && s_reg.st != DEV_CONVERT) begin
      // new conversion; a rise during conversion is ignored
      s_next.st        = DEV_CONVERT;
      s_next.chain     = ~s_reg.sdiSync;
      s_next.busyChain = s_reg.sckSync;
      s_next.busy      = 1'b0;
      s_next.convCnt   = '0;
      s_next.fallCnt   = '0;
      s_next.shiftReg  = clampCode;
      s_next.sdoOe     = 1'b0;
    end else begin
      case (s_reg.st)
        DEV_STANDBY: begin
          // idle line is driven low while both select inputs are low
          s_next.sdoOut = 1'b0;
          s_next.sdoOe  = ~s_reg.cnvSync & ~s_reg.sdiSync;
        end
        DEV_CONVERT: begin
          // conversion timed by the internal counter only
          s_next.sdoOe   = 1'b0;
          s_next.convCnt = s_reg.convCnt + 1'b1;
          if (s_reg.convCnt == CONV_CNT_W'(CONV_CYCLES - 1)) begin
            s_next.busy    = busyNow;
            s_next.fallCnt = '0;
            s_next.result  = s_reg.shiftReg;
            if (busyNow) begin
              // start bit: low in select mode, high in chain mode
              s_next.sdoOe  = 1'b1;
              s_next.sdoOut = s_reg.chain;
              s_next.st     = DEV_SHIFT;
            end else if (s_reg.chain) begin
              s_next.sdoOe    = 1'b1;
              s_next.sdoOut   = s_reg.shiftReg[15];
              s_next.shiftReg = {s_reg.shiftReg[14:0], s_reg.sdiSync};
              s_next.st       = DEV_SHIFT;
            end else begin
              s_next.st = DEV_READY;
            end
          end
        end
        DEV_READY: begin
          // acquisition and standby until the host selects the port
          if (selected) begin
            s_next.sdoOe    = 1'b1;
            s_next.sdoOut   = s_reg.shiftReg[15];
            s_next.shiftReg = {s_reg.shiftReg[14:0], s_reg.sdiSync};
            s_next.fallCnt  = '0;
            s_next.st       = DEV_SHIFT;
          end
        end
        DEV_SHIFT: begin
          if (s_reg.chain ? ~s_reg.cnvSync : ~selected) begin
            // deselect releases the line at once
            s_next.sdoOe = 1'b0;
            s_next.st    = DEV_STANDBY;
          end else if (sckFall) begin
            if (!s_reg.chain && s_reg.fallCnt == lastFall) begin
              s_next.sdoOe = 1'b0;
              s_next.st    = DEV_STANDBY;
            end else begin
              // bit changes only on a fall, so it stands across the rise
              s_next.sdoOut   = s_reg.shiftReg[15];
              s_next.shiftReg = {s_reg.shiftReg[14:0], s_reg.sdiSync};
              s_next.fallCnt  = s_reg.fallCnt + 1'b1;
            end
          end
        end
        default: begin
          s_next.st    = DEV_STANDBY;
          s_next.sdoOe = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg         <= '0;
      s_reg.sdiMeta <= 1'b1; // data-in idles high: no false low drive after reset
      s_reg.sdiSync <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // link and status outputs
  assign link.sdoOut   = s_reg.sdoOut;
  assign link.sdoOe    = s_reg.sdoOe;
  assign resultOut     = s_reg.result;
  assign converting    = (s_reg.st == DEV_CONVERT);
  assign chainMode     = s_reg.chain;
  assign busyMode      = s_reg.busy;
  assign readoutActive = (s_reg.st == DEV_SHIFT);

endmodule : asrp_device

/* File: tb/asrp_link_sva.sv */
// link checks between host end and converter end of the serial readout port
`timescale 1ns/1ps
module asrp_link_sva
  import asrp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link signals
  input wire logic convStart,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe
);
  logic [9:0] sinceRise_reg;
  logic [4:0] fallCnt_reg;
  logic       busyArm_reg;
  logic       cnvPrev_reg;
  logic       sckPrev_reg;
  logic       oePrev_reg;
  logic [4:0] lastFall;

  // count of the final clock fall of a frame, one more with the busy start bit
  assign lastFall = busyArm_reg ? 5'(FALLS_BUSY - 1) : 5'(FALLS_PLAIN - 1);

  // cycles since start rise, busy choice of the host, falls inside a frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sinceRise_reg <= 10'h3FF;
      fallCnt_reg   <= 5'h00;
      busyArm_reg   <= 1'b0;
      cnvPrev_reg   <= 1'b0;
      sckPrev_reg   <= 1'b0;
      oePrev_reg    <= 1'b0;
    end else begin
      cnvPrev_reg <= convStart;
      sckPrev_reg <= sck;
      oePrev_reg  <= sdoOe;
      if (convStart && !cnvPrev_reg) begin
        sinceRise_reg <= 10'h000;
      end else if (sinceRise_reg != 10'h3FF) begin
        sinceRise_reg <= sinceRise_reg + 10'h001;
      end
      if (sinceRise_reg == 10'h008) begin
        busyArm_reg <= !(convStart && sdi);
      end
      if (sdoOe && !oePrev_reg) begin
        fallCnt_reg <= 5'h00;
      end else if (sdoOe && sckPrev_reg && !sck) begin
        fallCnt_reg <= fallCnt_reg + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // frame steps: the line stays driven, then is let go shortly after the last fall
  sequence s_stay_on;
    sdoOe [*8];
  endsequence
  sequence s_release;
    ##[1:6] !sdoOe;
  endsequence

  // assertions on host and converter behaviour at the link
  a_select_level: assert property ($rose(convStart) |-> sdi && !sck)
    else $error("start rose without select level");
  a_float_convert: assert property (sinceRise_reg > 5 && sinceRise_reg < CONV_CYCLES |-> !sdoOe)
    else $error("data line driven during conversion");
  a_wait_conv: assert property ($fell(sck) |-> sinceRise_reg >= CONV_CYCLES)
    else $error("readout began before conversion time");
  a_sck_quiet: assert property (sinceRise_reg < CONV_CYCLES |-> !sck)
    else $error("serial clock moved during conversion");
  a_mode_hold: assert property (sinceRise_reg > 8 && sinceRise_reg < CONV_CYCLES |-> busyArm_reg == !(convStart && sdi))
    else $error("select level changed during conversion");
  a_busy_low: assert property ($rose(sdoOe) && busyArm_reg |-> !sdoOut && sinceRise_reg >= CONV_CYCLES)
    else $error("busy start bit wrong");
  a_msb_select: assert property ($fell(convStart && sdi) && !busyArm_reg && sinceRise_reg > CONV_CYCLES + 4 |-> ##[1:6] sdoOe)
    else $error("no data after select");
  a_hold_frame: assert property ($fell(sck) && sdoOe && fallCnt_reg < lastFall |-> ##1 s_stay_on)
    else $error("data line released early");
  a_end_frame: assert property ($fell(sck) && sdoOe && fallCnt_reg == lastFall |-> s_release)
    else $error("data line not released after last fall");
  a_bit_steady: assert property (sdoOe && $rose(sck) |-> $stable(sdoOut) ##1 ($stable(sdoOut) && sdoOe) [*6])
    else $error("data bit changed around clock rise");
endmodule : asrp_link_sva

/* File: tb/adc_serial_readout_port_test.sv */
// self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ps
module adc_serial_readout_port_test;
  import asrp_pkg::*;
  logic               clock = 1'b0;
  logic               resetn = 1'b0;
  logic               hsel = 1'b0;
  logic        [31:0] haddr = 32'h0;
  logic        [1:0]  htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic        [31:0] hwdata = 32'h0;
  logic signed [17:0] sampleIn = 18'sh00000;
  logic        [31:0] hrdata;
  logic               hreadyout;
  logic               hresp;
  logic        [15:0] resultOut;
  logic               chainMode;
  logic               busyMode;
  logic               converting;
  logic               readoutActive;
  logic        [31:0] rng = 32'h00008F57;
  logic        [31:0] wireBits = 32'h0;
  logic               sckPrev = 1'b0;
  int                 wireN = 0;
  int                 convN = 0;
  int                 actN = 0;
  int                 nFail = 0;
  int                 samplesChecked = 0;

  always #2.5 clock = ~clock;

  asrp_if link();
  asrp_host i_asrp_host (.clock(clock), .resetn(resetn), .link(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  asrp_device i_asrp_device (.clock(clock), .resetn(resetn), .link(link),
    .sampleIn(sampleIn), .resultOut(resultOut), .converting(converting),
    .chainMode(chainMode), .busyMode(busyMode), .readoutActive(readoutActive));
  asrp_link_sva i_asrp_link_sva (.clock(clock), .resetn(resetn), .convStart(link.convStart),
    .sck(link.sck), .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe));

  // capture the data line at each serial clock rise while driven; count conversion cycles
  always @(posedge clock) begin
    sckPrev <= link.sck;
    if (converting === 1'b1) begin
      convN <= convN + 1;
    end
    if (link.sck && !sckPrev && link.sdoOe) begin
      wireBits <= {wireBits[30:0], link.sdoLine};
      wireN <= wireN + 1;
      if (readoutActive === 1'b1) begin
        actN <= actN + 1;
      end
    end
  end

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  // straight binary code with out-of-range inputs clamped
  function automatic logic [15:0] clamp_code(input logic signed [17:0] s);
    if (s < 0) return 16'h0000;
    if (s > 18'sh0FFFF) return 16'hFFFF;
    return s[15:0];
  endfunction : clamp_code

  task automatic testDone();
    if (nFail == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : testDone

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask : chk

  // one single word transfer: address phase, then data phase
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus_xfer

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask : rd_chk

  // one conversion and readout in the given wiring and busy choice
  task automatic run_conv(input logic fw, input logic bz, input logic signed [17:0] s);
    logic [31:0] q;
    logic [31:0] m;
    logic [15:0] e;
    m = {29'h0, bz, fw, 1'b0};
    e = clamp_code(s);
    sampleIn <= s;
    wireN = 0;
    wireBits = 32'h0;
    convN = 0;
    actN = 0;
    bus_xfer(1'b1, REG_CTRL, m, q);
    rd_chk("ctrl", REG_CTRL, m);
    bus_xfer(1'b1, REG_CTRL, m | 32'h1, q);
    bus_xfer(1'b1, REG_CTRL, m | 32'h1, q);  // second start while busy is dropped
    q = 32'h0;
    while (q !== 32'h2) bus_xfer(1'b0, REG_STATUS, 32'h0, q);
    chk("bit count", bz ? 32'h11 : 32'h10, 32'(wireN));
    chk("wire bits", {16'h0, e}, wireBits);
    chk("busy mode", {31'h0, bz}, {31'h0, busyMode});
    chk("chain mode", 32'h0, {31'h0, chainMode});
    chk("result", {16'h0, e}, {16'h0, resultOut});
    chk("conversion cycles", 32'(CONV_CYCLES), 32'(convN));
    chk("readout active", bz ? 32'h11 : 32'h10, 32'(actN));
    rd_chk("data", REG_DATA, {16'h0, e});
    rd_chk("status after read", REG_STATUS, 32'h0);
  endtask : run_conv

  // main sequence: reset, register checks, corner and random conversions
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic signed [17:0] s;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_chk("ctrl reset", REG_CTRL, 32'h0);
    bus_xfer(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    rd_chk("unmapped", 8'h0C, 32'h0);
    for (int i = 0; i < 24; i++) begin
      r = xorshift();
      if (i == 12) begin
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rd_chk("ctrl reset", REG_CTRL, 32'h0);
      end
      if (i < 4) s = -18'sh00003;
      else if (i < 8) s = 18'sh1FFFF;
      else if (i < 12) s = (i[0]) ? 18'sh0FFFF : 18'sh00000;
      else s = i[2] ? $signed(r[17:0]) : $signed({2'b00, r[15:0]});
      run_conv(i[0], i[1], s);
    end
    testDone();
  end

  // watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge clock);
    nFail++;
    testDone();
  end
endmodule : adc_serial_readout_port_test
